// File: design/acf_core.v
// Purpose: Converter control, result formatting, trigger select and scan selection
// Assumes: AXI4-Lite registers and converter core on the same clock; triggers are synchronised to it
// Notes: Conversion timing is modelled by counters
`include "acf_map.vh"
`default_nettype none
module acf_core (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire motor_pwm_interval,
    input wire ext_trigger,
    input wire timer_trigger,
    input wire [11:0] sample_data,
    input wire device_idle,
    output reg converter_enable,
    output reg sampling,
    output reg [4:0] analog_input_n,
    output reg low_reference_level,
    output reg [15:0] result_word,
    output reg result_valid,
    output reg [15:0] dma_address
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_CONVERT = 3'b100;

    reg [15:0] converter_control_one;
    reg [15:0] scan_select_low;
    reg [15:0] scan_select_high;
    reg [7:0] dma_buf_size;
    reg [15:0] standalone_addr;
    reg [2:0] state;
    reg [4:0] cycle_count;
    reg [4:0] scan_index;
    reg [11:0] raw_result;
    reg [15:0] next_dma;
    reg pwm_s1, pwm_s2, pwm_s3;
    reg ext_s1, ext_s2, ext_s3;
    reg tmr_s1, tmr_s2, tmr_s3;
    reg aw_held, w_held;
    reg [4:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire [31:0] scan_all = {scan_select_high, scan_select_low};
    wire conv_on = converter_control_one[`ACF_BIT_ON] &
        ~(converter_control_one[`ACF_BIT_IDLE] & device_idle);
    wire [2:0] ssrc = converter_control_one[`ACF_SSRC_HI:`ACF_SSRC_LO];
    wire [1:0] form = converter_control_one[`ACF_FORM_HI:`ACF_FORM_LO];
    wire res12 = converter_control_one[`ACF_BIT_RES12];
    wire pwm_edge = pwm_s2 & ~pwm_s3;
    wire ext_edge = ext_s2 & ~ext_s3;
    wire tmr_edge = tmr_s2 & ~tmr_s3;

    // Result packing by resolution and format
    function [15:0] pack_result;
        input [11:0] d;
        input r12;
        input [1:0] f;
        begin
            if (r12) begin
                case (f)
                    2'h0: pack_result = {4'h0, d};
                    2'h1: pack_result = {{5{~d[11]}}, d[10:0]};
                    2'h2: pack_result = {d, 4'h0};
                    default: pack_result = {~d[11], d[10:0], 4'h0};
                endcase
            end else begin
                case (f)
                    2'h0: pack_result = {6'h00, d[9:0]};
                    2'h1: pack_result = {{7{~d[9]}}, d[8:0]};
                    2'h2: pack_result = {d[9:0], 6'h00};
                    default: pack_result = {~d[9], d[8:0], 6'h00};
                endcase
            end
        end
    endfunction

    // Next selected input after idx, wrapping
    function [4:0] next_scan;
        input [31:0] sel;
        input [4:0] idx;
        integer k;
        reg found;
        reg [4:0] cand;
        begin
            found = 1'b0;
            next_scan = idx;
            cand = idx;
            for (k = 1; k <= 32; k = k + 1) begin
                cand = idx + k[4:0];
                if (!found && sel[cand]) begin
                    next_scan = cand;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // Trigger synchronisers
    always @(posedge aclk) begin
        if (!aresetn) begin
            {pwm_s1, pwm_s2, pwm_s3} <= 3'h0;
            {ext_s1, ext_s2, ext_s3} <= 3'h0;
            {tmr_s1, tmr_s2, tmr_s3} <= 3'h0;
        end else begin
            pwm_s1 <= motor_pwm_interval;
            pwm_s2 <= pwm_s1;
            pwm_s3 <= pwm_s2;
            ext_s1 <= ext_trigger;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            tmr_s1 <= timer_trigger;
            tmr_s2 <= tmr_s1;
            tmr_s3 <= tmr_s2;
        end
    end

    reg end_sample;
    always @* begin
        case (ssrc)
            `ACF_SSRC_MANUAL: end_sample = ~converter_control_one[`ACF_BIT_SAMPLE];
            3'h1: end_sample = ext_edge;
            3'h2: end_sample = tmr_edge;
            `ACF_SSRC_PWM: end_sample = pwm_edge;
            `ACF_SSRC_AUTO: end_sample = (cycle_count == `ACF_AUTO_SAMPLE_CYC);
            default: end_sample = 1'b0;
        endcase
    end

    always @* begin
        if (converter_control_one[`ACF_BIT_DMA_ORDER])
            next_dma = standalone_addr;
        else
            next_dma = {3'h0, analog_input_n, dma_buf_size};
    end

    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire wr_ctrl = do_write & (aw_addr_q == `ACF_OFS_CTRL);
    wire [15:0] wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // Converter sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            cycle_count <= 5'h00;
            scan_index <= 5'h00;
            raw_result <= 12'h000;
            converter_enable <= 1'b0;
            sampling <= 1'b0;
            analog_input_n <= 5'h00;
            low_reference_level <= 1'b0;
            result_word <= 16'h0000;
            result_valid <= 1'b0;
            dma_address <= 16'h0000;
            standalone_addr <= 16'h0000;
        end else begin
            converter_enable <= conv_on;
            result_valid <= 1'b0;
            dma_address <= next_dma;
            low_reference_level <= ({1'b0, analog_input_n} >= `ACF_NUM_INPUTS);
            case (state)
                ST_IDLE: begin
                    cycle_count <= 5'h00;
                    if (conv_on && ssrc != 3'h4 && ssrc != 3'h5 && ssrc != 3'h6 &&
                        (converter_control_one[`ACF_BIT_AUTO_SAMPLE] ||
                         converter_control_one[`ACF_BIT_SAMPLE])) begin
                        state <= ST_SAMPLE;
                        sampling <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    cycle_count <= cycle_count + 5'h01;
                    if (!conv_on) begin
                        state <= ST_IDLE;
                        sampling <= 1'b0;
                    end else if (end_sample) begin
                        state <= ST_CONVERT;
                        sampling <= 1'b0;
                        cycle_count <= 5'h00;
                        raw_result <= low_reference_level ? 12'h000 : sample_data;
                    end
                end
                ST_CONVERT: begin
                    cycle_count <= cycle_count + 5'h01;
                    if (!conv_on) begin
                        state <= ST_IDLE;
                    end else if (cycle_count == `ACF_CONV_CYC) begin
                        state <= ST_IDLE;
                        result_word <= pack_result(raw_result, res12, form);
                        result_valid <= 1'b1;
                        standalone_addr <= standalone_addr + 16'h0001;
                        scan_index <= next_scan(scan_all, scan_index);
                        analog_input_n <= next_scan(scan_all, scan_index);
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Register file
    always @(posedge aclk) begin
        if (!aresetn) begin
            converter_control_one <= `ACF_CTRL_RESET;
            scan_select_low <= `ACF_SCAN_RESET;
            scan_select_high <= `ACF_SCAN_RESET;
            dma_buf_size <= `ACF_DMA_SIZE_RESET;
        end else begin
            if (state == ST_SAMPLE && end_sample && ssrc != `ACF_SSRC_MANUAL &&
                converter_control_one[`ACF_BIT_AUTO_SAMPLE] == 1'b0)
                converter_control_one[`ACF_BIT_SAMPLE] <= 1'b0;
            if (wr_ctrl)
                converter_control_one <= (converter_control_one & ~(wmask & `ACF_CTRL_WMASK)) |
                    (w_data_q[15:0] & wmask & `ACF_CTRL_WMASK) |
                    (converter_control_one & 16'h0001 & ~(wmask & ~w_data_q[15:0]));
            // Hardware set of the done flag wins over a clearing write
            if (state == ST_CONVERT && cycle_count == `ACF_CONV_CYC && conv_on)
                converter_control_one[`ACF_BIT_DONE] <= 1'b1;
            if (do_write && aw_addr_q == `ACF_OFS_SCAN_LOW)
                scan_select_low <= (scan_select_low & ~wmask) | (w_data_q[15:0] & wmask);
            if (do_write && aw_addr_q == `ACF_OFS_SCAN_HIGH)
                scan_select_high <= (scan_select_high & ~wmask) | (w_data_q[15:0] & wmask);
            if (do_write && aw_addr_q == `ACF_OFS_DMA_ADDR && w_strb_q[0])
                dma_buf_size <= w_data_q[7:0];
        end
    end

    // AXI4-Lite write channel
    function known_addr;
        input [4:0] a;
        begin
            known_addr = (a == `ACF_OFS_CTRL) || (a == `ACF_OFS_SCAN_LOW) || (a == `ACF_OFS_SCAN_HIGH) ||
                (a == `ACF_OFS_STATUS) || (a == `ACF_OFS_RAW) || (a == `ACF_OFS_RESULT) ||
                (a == `ACF_OFS_DMA_ADDR);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ACF_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_addr(aw_addr_q) ? `ACF_RESP_OKAY : `ACF_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ACF_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known_addr(s_axi_araddr) ? `ACF_RESP_OKAY : `ACF_RESP_SLVERR;
                case (s_axi_araddr)
                    `ACF_OFS_CTRL: s_axi_rdata <= {16'h0, converter_control_one};
                    `ACF_OFS_SCAN_LOW: s_axi_rdata <= {16'h0, scan_select_low};
                    `ACF_OFS_SCAN_HIGH: s_axi_rdata <= {16'h0, scan_select_high};
                    `ACF_OFS_STATUS: s_axi_rdata <= {24'h0, converter_enable, state, analog_input_n[3:0]};
                    `ACF_OFS_RAW: s_axi_rdata <= {20'h0, raw_result};
                    `ACF_OFS_RESULT: s_axi_rdata <= {16'h0, result_word};
                    `ACF_OFS_DMA_ADDR: s_axi_rdata <= {8'h0, dma_address, dma_buf_size};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: design/acf_map.vh
// Purpose: Register offsets, field positions and reset values for the converter control block
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: Definitions only
`ifndef ACF_MAP_VH
`define ACF_MAP_VH
`define ACF_OFS_CTRL 5'h00
`define ACF_OFS_SCAN_LOW 5'h04
`define ACF_OFS_SCAN_HIGH 5'h08
`define ACF_OFS_STATUS 5'h0c
`define ACF_OFS_RAW 5'h10
`define ACF_OFS_RESULT 5'h14
`define ACF_OFS_DMA_ADDR 5'h18
`define ACF_ADDR_W 5
`define ACF_CTRL_RESET 16'h0000
`define ACF_SCAN_RESET 16'h0000
`define ACF_CTRL_WMASK 16'hb7ee
`define ACF_BIT_ON 15
`define ACF_BIT_IDLE 13
`define ACF_BIT_DMA_ORDER 12
`define ACF_BIT_RES12 10
`define ACF_FORM_HI 9
`define ACF_FORM_LO 8
`define ACF_SSRC_HI 7
`define ACF_SSRC_LO 5
`define ACF_BIT_SIMULTANEOUS_SAMPLE 3
`define ACF_BIT_AUTO_SAMPLE 2
`define ACF_BIT_SAMPLE 1
`define ACF_BIT_DONE 0
`define ACF_SSRC_MANUAL 3'h0
`define ACF_SSRC_PWM 3'h3
`define ACF_SSRC_AUTO 3'h7
`define ACF_AUTO_SAMPLE_CYC 5'h1f
`define ACF_CONV_CYC 5'h0e
`define ACF_NUM_INPUTS 6'h12
`define ACF_DMA_SIZE_RESET 8'h01
`define ACF_RESP_OKAY 2'h0
`define ACF_RESP_SLVERR 2'h2
`endif

// File: bench/acf_partner.sv
// Purpose: Far-side model: analog level and motor PWM interval source
// Assumes: Level steady over each sample phase
// Notes: Pin and timer triggers stay quiet
`default_nettype none
module acf_partner #(parameter logic [11:0] level = 12'hab5) (
    input wire logic aclk,
    input wire logic pwm_run,
    output logic motor_pwm_interval,
    output logic ext_trigger,
    output logic timer_trigger,
    output logic [11:0] sample_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] phase = 6'h00;
    always @(posedge aclk) begin
        phase <= pwm_run ? phase + 6'h01 : 6'h00;
    end
    // Interval end pulse, four cycles in every 64
    assign motor_pwm_interval = pwm_run && phase[5:2] == 4'hf;
    assign ext_trigger = 1'b0;
    assign timer_trigger = 1'b0;
    assign sample_data = level;
endmodule
`default_nettype wire

// File: bench/acf_monitor.sv
// Purpose: Port checks for the converter control block
// Assumes: Control writes offer address and data together
// Notes: Control fields tracked by snooping write channels
`default_nettype none
module acf_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic motor_pwm_interval,
    input wire logic converter_enable,
    input wire logic sampling,
    input wire logic [4:0] analog_input_n,
    input wire logic low_reference_level,
    input wire logic [15:0] result_word,
    input wire logic result_valid,
    input wire logic [15:0] dma_address
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ctrl_q;
    logic [5:0] sample_enable_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always @(posedge aclk) begin
        if (!aresetn) ctrl_q <= 16'h0000;
        else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 5'h00)
            ctrl_q <= s_axi_wdata[15:0];
    end
    always @(posedge aclk) begin
        if (!aresetn || !sampling) sample_enable_cnt <= 6'h00;
        else if (sample_enable_cnt != 6'h3f) sample_enable_cnt <= sample_enable_cnt + 6'h01;
    end
    property p_off; !ctrl_q[15] [*3] |-> !converter_enable && !sampling && !result_valid; endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_dma; !ctrl_q[12] && $stable(ctrl_q) && ctrl_q == $past(ctrl_q, 2) && $stable(analog_input_n)
        && $past(aresetn) |-> dma_address == {3'h0, analog_input_n, 8'h01}; endproperty
    a_dma: assert property (p_dma) else $error("scatter address wrong");
    property p_f03; result_valid && ctrl_q[10:8] == 3'h0 |-> result_word[15:10] == 6'h00; endproperty
    a_f03: assert property (p_f03) else $error("10-bit integer wrong");
    property p_f04; result_valid && ctrl_q[10:8] == 3'h1 |-> result_word[15:9] == 7'h00 || result_word[15:9] == 7'h7f;
    endproperty
    a_f04: assert property (p_f04) else $error("10-bit signed wrong");
    property p_f05; result_valid && ctrl_q[10:8] == 3'h3 |-> result_word[5:0] == 6'h00; endproperty
    a_f05: assert property (p_f05) else $error("10-bit fraction wrong");
    property p_f06; result_valid && ctrl_q[10:8] == 3'h4 |-> result_word[15:12] == 4'h0; endproperty
    a_f06: assert property (p_f06) else $error("12-bit integer wrong");
    property p_auto; $fell(sampling) && ctrl_q[15] && ctrl_q[7:5] == 3'h7 |-> sample_enable_cnt >= 6'h1e && sample_enable_cnt <= 6'h21;
    endproperty
    a_auto: assert property (p_auto) else $error("auto sample length wrong");
    property p_pwm; ctrl_q[15] && ctrl_q[7:5] == 3'h3 && sampling && $rose(motor_pwm_interval) |-> ##[1:6] !sampling;
    endproperty
    a_pwm: assert property (p_pwm) else $error("PWM end ignored");
    property p_lowref; $stable(analog_input_n) |-> low_reference_level == (analog_input_n >= 5'h12); endproperty
    a_lowref: assert property (p_lowref) else $error("low reference flag wrong");
    property p_resv; ctrl_q[7:5] >= 3'h4 && ctrl_q[7:5] <= 3'h6 && !sampling |=> !sampling; endproperty
    a_resv: assert property (p_resv) else $error("reserved source sampled");
    property p_reset; $rose(aresetn) |-> !converter_enable && !sampling && !result_valid && result_word == 16'h0000;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not clear at reset");
    c_result: cover property (result_valid);
    c_absent: cover property (result_valid && low_reference_level);
    c_pwm: cover property ($fell(sampling) && ctrl_q[7:5] == 3'h3);
endmodule
bind acf_core acf_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .motor_pwm_interval, .converter_enable, .sampling, .analog_input_n,
    .low_reference_level, .result_word, .result_valid, .dma_address);
`default_nettype wire

// File: bench/testbench.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: AXI4-Lite master tasks; partner gives a steady level
// Notes: Expected words built from the format rules
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] lv = 12'hab5;
    localparam logic [31:0] ctl [5] = '{32'h80e4, 32'h81e4, 32'h83e4, 32'h84e4, 32'h85e4};
    localparam logic [15:0] fmt [5] = '{{6'h0, lv[9:0]}, {{7{~lv[9]}}, lv[8:0]}, {~lv[9], lv[8:0], 6'h0},
        {4'h0, lv}, {{5{~lv[11]}}, lv[10:0]}};
    logic aclk = 1'b0, aresetn = 1'b0, pwm_run = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, converter_enable, sampling;
    logic motor_pwm_interval, ext_trigger, timer_trigger, low_reference_level, result_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] sample_data;
    logic [4:0] analog_input_n;
    logic [15:0] result_word, dma_address;
    int failures = 0, tests_run = 0;
    initial begin
        forever #2 aclk = ~aclk;
    end
    acf_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .motor_pwm_interval, .ext_trigger, .timer_trigger, .sample_data,
        .device_idle(1'b0), .converter_enable, .sampling, .analog_input_n, .low_reference_level, .result_word,
        .result_valid, .dma_address);
    acf_partner #(.level(lv)) u_far (.aclk, .pwm_run, .motor_pwm_interval, .ext_trigger, .timer_trigger,
        .sample_data);
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic toolong(input int n);
        if (n >= 60) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] resp);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 60);
        s_axi_bready <= 1'b0;
        toolong(n);
        chk({30'h0, s_axi_bresp}, {30'h0, resp});
        @(posedge aclk);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] resp);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 60);
        s_axi_rready <= 1'b0;
        toolong(n);
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, resp});
        @(posedge aclk);
    endtask
    task automatic wait_res(output logic hit);
        hit = 1'b0;
        for (int n = 0; n < 200 && !hit; n++) begin
            @(posedge aclk);
            hit = result_valid;
        end
    endtask
    initial begin
        logic hit;
        logic [15:0] d1;
        logic [31:0] seen;
        logic [4:0] cur;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(5'h00, 32'h0, 2'h0);
        rdc(5'h04, 32'h0, 2'h0);
        rdc(5'h08, 32'h0, 2'h0);
        rdc(5'h18, 32'h0000_0101, 2'h0);
        rdc(5'h1c, 32'h0, 2'h2);
        wr(5'h1c, 32'hffff, 2'h2);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(5'h00, 32'h0, 2'h0);
            wr(5'h00, ctl[i], 2'h0);
            wait_res(hit);
            chk({30'h0, hit, converter_enable}, 32'h3);
            chk({16'h0, result_word}, {16'h0, fmt[i]});
            rdc(5'h14, {16'h0, fmt[i]}, 2'h0);
        end
        $display("test formats done");
        wr(5'h00, 32'h0, 2'h0);
        wr(5'h00, 32'h8064, 2'h0);
        wait_res(hit);
        chk({31'h0, hit}, 32'h0);
        pwm_run <= 1'b1;
        wait_res(hit);
        chk({31'h0, hit}, 32'h1);
        pwm_run <= 1'b0;
        for (int s = 4; s < 7; s++) begin
            wr(5'h00, 32'h0, 2'h0);
            wr(5'h00, 32'h8004 | (s << 5), 2'h0);
            wait_res(hit);
            chk({31'h0, hit}, 32'h0);
        end
        $display("test sources done");
        wr(5'h00, 32'h0, 2'h0);
        wr(5'h04, 32'hffff_ffff, 2'h0);
        rdc(5'h04, 32'hffff, 2'h0);
        wr(5'h08, 32'hffff_ffff, 2'h0);
        s_axi_wstrb <= 4'h2;
        wr(5'h08, 32'h0000_0012, 2'h0);
        rdc(5'h08, 32'h00ff, 2'h0);
        s_axi_wstrb <= 4'hf;
        wr(5'h08, 32'h0000_0012, 2'h0);
        wr(5'h04, 32'h0000_0004, 2'h0);
        wr(5'h00, 32'h80e4, 2'h0);
        seen = 32'h0;
        for (int i = 0; i < 8; i++) begin
            cur = analog_input_n;
            wait_res(hit);
            if (i > 1) seen[analog_input_n] = 1'b1;
            if (i > 1) chk({16'h0, result_word}, (cur >= 5'h12) ? 32'h0 : {22'h0, lv[9:0]});
        end
        chk(seen, 32'h0012_0004);
        wr(5'h00, 32'h90e4, 2'h0);
        wait_res(hit);
        d1 = dma_address;
        wait_res(hit);
        chk({16'h0, dma_address - d1}, 32'h1);
        $display("test scan done");
        wr(5'h00, 32'h0, 2'h0);
        wait_res(hit);
        chk({30'h0, hit, converter_enable}, 32'h0);
        $display("test off done");
        wrap_up();
    end
endmodule
`default_nettype wire
